/* hw/snv_pkg.sv */
// Shared constants and types for the serial nonvolatile command port
package snv_pkg;

  // Array geometry
  localparam int ADDR_W   = 18;                 // Byte address width
  localparam int DATA_W   = 8;                  // Byte width
  localparam int ADDR_BYTES = 3;                // Address bytes per access

  // Opcodes
  localparam logic [7:0] OP_SET_LATCH   = 8'h06; // set_write_latch_cmd
  localparam logic [7:0] OP_CLR_LATCH   = 8'h04; // clear_write_latch_cmd
  localparam logic [7:0] OP_STAT_READ   = 8'h05; // status_read_cmd
  localparam logic [7:0] OP_STAT_WRITE  = 8'h01; // status_write_cmd
  localparam logic [7:0] OP_MEM_READ    = 8'h03; // Memory read
  localparam logic [7:0] OP_FAST_READ   = 8'h0b; // fast_read_cmd
  localparam logic [7:0] OP_MEM_WRITE   = 8'h02; // Memory write
  localparam logic [7:0] OP_SLEEP       = 8'hb9; // Sleep entry
  localparam logic [7:0] OP_ID_READ     = 8'h9f; // id_read_cmd

  // Status byte field positions
  localparam int POS_LATCH     = 1;             // write_latch_flag
  localparam int POS_GUARD_LOW = 2;             // block_guard_bit_low
  localparam int POS_GUARD_HI  = 3;             // block_guard_bit_high
  localparam int POS_PIN_EN    = 7;             // guard_pin_enable

  // Fixed bits: 0, 4, 5 read zero, 6 reads one
  localparam logic [7:0] STAT_FIXED   = 8'h40;
  // Reset values of the writable fields
  localparam logic       LATCH_RST    = 1'b0;
  localparam logic [1:0] GUARD_RST    = 2'h0;
  localparam logic       PIN_EN_RST   = 1'b0;

  // Guarded region bounds
  localparam logic [ADDR_W-1:0] GUARD_QUARTER = 18'h30000;
  localparam logic [ADDR_W-1:0] GUARD_HALF    = 18'h20000;

  // Bit and address byte counter end values
  localparam logic [2:0] LAST_BIT  = 3'h7;
  localparam logic [1:0] LAST_ADDR = 2'h2;

  // Front-end states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_OPCODE,
    ST_ADDR,
    ST_WDATA,
    ST_SRWRITE,
    ST_SREAD,
    ST_PASS,
    ST_IGNORE
  } snv_state_t;

  // Commands handed to the read, sleep and id logic outside
  typedef enum logic [2:0] {
    CMD_NONE,
    CMD_READ,
    CMD_FAST_READ,
    CMD_SLEEP,
    CMD_ID_READ
  } snv_cmd_t;

  // One byte bound for the array
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } snv_wr_word_t;

endpackage

/* hw/snv_cmd_port.sv */
`timescale 1ns/1ps
// What this block does
// - Three address bytes, low 18 bits kept
// - First byte after select is opcode
// - Bad opcode: ignore input, output stays off
// - Sample on rising, drive on falling edge
// - Clock level at select picks mode
// - Decode set, clear latch, status write
// - Decode status read, read, fast read
// - Decode write, sleep, id; rest invalid
// - Latch clear at reset, gates writes
// - Only set command raises the latch
// - Latch cleared at deselect after writes
// - Bits 0,4,5 read zero, 6 one
// - Latch bit1, guards bits2-3, pin bit7
// - Guard bits kept across power loss
// - Guard codes select protected upper ranges
// - Guard pin blocks status write if enabled
// - Pin never blocks array writes
// - Status read shifts out status byte
// - Status write updates pin enable, guards
// - Memory write: opcode, address, data bytes
// - Address increments, wraps to zero
// - MSB first; deselect ends write
// - One opcode per select period
// - Guarded address stops the burst
// - Each byte committed at eighth bit
// - Deselected: ignore input, output off
module snv_cmd_port (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst,
  // Serial pins, asynchronous to clk
  input  wire logic               cs_n,
  input  wire logic               sck,
  input  wire logic               si,
  input  wire logic               guard_pin_n,
  output logic                    so,
  output logic                    so_oe,
  // Guard bit storage outside the power domain
  input  wire logic               nv_restore_valid,
  input  wire logic [1:0]         nv_restore_guard,
  input  wire logic               nv_restore_pin_en,
  output logic [7:0]              status_protect_reg,
  // Array write port
  output snv_pkg::snv_wr_word_t   mem_wr_word,
  output logic                    mem_wr_valid,
  input  wire logic               mem_wr_ready,
  output logic                    wr_overrun,
  // Decoded commands for read, sleep and id logic
  output logic                    cmd_strobe,
  output snv_pkg::snv_cmd_t       cmd_kind,
  output logic                    spi_mode3
);

  // Pin synchronisers: bit 0 cs_n, 1 sck, 2 si, 3 guard pin
  logic [3:0]                     pin_meta_reg;   // First stage only
  logic [3:0]                     pin_sync_reg;   // Safe to read
  logic [1:0]                     pin_prev_reg;   // For cs and sck edges

  // Front end state
  snv_pkg::snv_state_t            state_reg;
  logic [2:0]                     bit_cnt_reg;    // Bit within byte
  logic [7:0]                     rx_shift_reg;   // Incoming bits
  logic [1:0]                     addr_cnt_reg;   // Address byte count
  logic [snv_pkg::ADDR_W-1:0]     addr_reg;       // Burst address
  logic                           burst_stop_reg; // Guarded hit seen
  logic                           clr_pend_reg;   // Clear latch at deselect

  // Status fields
  logic                           write_latch_flag_reg;
  logic                           block_guard_bit_low_reg;
  logic                           block_guard_bit_high_reg;
  logic                           guard_pin_enable_reg;

  // Output shifter
  logic [7:0]                     tx_shift_reg;
  logic [2:0]                     tx_cnt_reg;

  // Two-entry write buffer
  snv_pkg::snv_wr_word_t          slot1_reg;
  logic                           slot1_valid_reg;

  // Decoded events
  logic                           cs_low;
  logic                           cs_fall;
  logic                           cs_rise;
  logic                           sck_rise;
  logic                           sck_fall;
  logic [7:0]                     rx_byte;
  logic                           byte_done;
  logic                           set_evt;
  logic                           srw_take;
  logic                           srw_ok;
  logic                           wr_take;
  logic                           addr_guarded;
  logic [7:0]                     status_now;
  logic                           buf_in_ready;
  logic                           buf_pop;
  snv_pkg::snv_wr_word_t          buf_in_word;

  // Two flops on every pin before use
  always_ff @(posedge clk) begin
    if (rst) begin
      // Idle levels: select, clock and guard pin high, no false edge
      pin_meta_reg <= 4'hb;
      pin_sync_reg <= 4'hb;
      pin_prev_reg <= 2'h3;
    end else begin
      pin_meta_reg <= {guard_pin_n, si, sck, cs_n};
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg[1:0];
    end
  end

  // Edge finding on the synchronised pins
  always_comb begin
    cs_low   = !pin_sync_reg[0];
    cs_fall  = pin_prev_reg[0] && !pin_sync_reg[0];
    cs_rise  = !pin_prev_reg[0] && pin_sync_reg[0];
    // Mode 3 idles high, so its first rise follows the first toggle
    sck_rise = cs_low && !pin_prev_reg[1] && pin_sync_reg[1];
    sck_fall = cs_low && pin_prev_reg[1] && !pin_sync_reg[1];
    rx_byte  = {rx_shift_reg[6:0], pin_sync_reg[2]};
    byte_done = sck_rise && (bit_cnt_reg == snv_pkg::LAST_BIT);
  end

  // Status byte as read, fixed bits forced
  always_comb begin
    status_now = snv_pkg::STAT_FIXED;
    status_now[snv_pkg::POS_LATCH]     = write_latch_flag_reg;
    status_now[snv_pkg::POS_GUARD_LOW] = block_guard_bit_low_reg;
    status_now[snv_pkg::POS_GUARD_HI]  = block_guard_bit_high_reg;
    status_now[snv_pkg::POS_PIN_EN]    = guard_pin_enable_reg;
  end

  // Guarded ranges from the two guard bits
  always_comb begin
    case ({block_guard_bit_high_reg, block_guard_bit_low_reg})
      2'h0:    addr_guarded = 1'b0;
      2'h1:    addr_guarded = (addr_reg >= snv_pkg::GUARD_QUARTER);
      2'h2:    addr_guarded = (addr_reg >= snv_pkg::GUARD_HALF);
      default: addr_guarded = 1'b1;
    endcase
  end

  // Write permissions; the pin only matters for the status byte
  always_comb begin
    set_evt  = byte_done && (state_reg == snv_pkg::ST_OPCODE)
               && (rx_byte == snv_pkg::OP_SET_LATCH);
    srw_take = byte_done && (state_reg == snv_pkg::ST_SRWRITE);
    srw_ok   = write_latch_flag_reg
               && !(guard_pin_enable_reg && !pin_sync_reg[3]);
    // Array writes gated by latch and guard bits only
    wr_take  = byte_done && (state_reg == snv_pkg::ST_WDATA)
               && write_latch_flag_reg && !burst_stop_reg
               && !addr_guarded;
    buf_in_word.addr = addr_reg;
    buf_in_word.data = rx_byte;
  end

  // Byte framing and command sequencing
  always_ff @(posedge clk) begin
    if (rst || !cs_low) begin
      state_reg      <= snv_pkg::ST_IDLE;
      bit_cnt_reg    <= 3'h0;
      rx_shift_reg   <= 8'h00;
      addr_cnt_reg   <= 2'h0;
      burst_stop_reg <= 1'b0;
    end else if (cs_fall) begin
      // Only a fresh select opens an opcode
      state_reg   <= snv_pkg::ST_OPCODE;
      bit_cnt_reg <= 3'h0;
    end else if (sck_rise) begin
      rx_shift_reg <= rx_byte;
      bit_cnt_reg  <= bit_cnt_reg + 3'h1;
      if (byte_done) begin
        case (state_reg)
          snv_pkg::ST_OPCODE: begin
            // First full byte is the opcode
            case (rx_byte)
              snv_pkg::OP_SET_LATCH,
              snv_pkg::OP_CLR_LATCH:  state_reg <= snv_pkg::ST_PASS;
              snv_pkg::OP_STAT_WRITE: state_reg <= snv_pkg::ST_SRWRITE;
              snv_pkg::OP_STAT_READ:  state_reg <= snv_pkg::ST_SREAD;
              snv_pkg::OP_MEM_READ,
              snv_pkg::OP_FAST_READ:  state_reg <= snv_pkg::ST_PASS;
              snv_pkg::OP_MEM_WRITE:  state_reg <= snv_pkg::ST_ADDR;
              snv_pkg::OP_SLEEP,
              snv_pkg::OP_ID_READ:    state_reg <= snv_pkg::ST_PASS;
              default:                state_reg <= snv_pkg::ST_IGNORE;
            endcase
            addr_cnt_reg <= 2'h0;
          end
          snv_pkg::ST_ADDR: begin
            // Top six address bits fall off the left end
            addr_reg     <= {addr_reg[9:0], rx_byte};
            addr_cnt_reg <= addr_cnt_reg + 2'h1;
            if (addr_cnt_reg == snv_pkg::LAST_ADDR) begin
              state_reg <= snv_pkg::ST_WDATA;
            end
          end
          snv_pkg::ST_WDATA: begin
            if (wr_take) begin
              // Natural 18-bit wrap from top to zero
              addr_reg <= addr_reg + 18'h00001;
            end else if (addr_guarded) begin
              burst_stop_reg <= 1'b1;
            end
          end
          // One data byte only; extra bytes ignored
          snv_pkg::ST_SRWRITE: state_reg <= snv_pkg::ST_PASS;
          default: state_reg <= state_reg;
        endcase
      end
    end
  end

  // Deferred latch clear after clearing or writing commands
  always_ff @(posedge clk) begin
    if (rst || cs_fall) begin
      clr_pend_reg <= 1'b0;
    end else if (byte_done && (state_reg == snv_pkg::ST_OPCODE)
                 && (rx_byte == snv_pkg::OP_CLR_LATCH
                     || rx_byte == snv_pkg::OP_STAT_WRITE
                     || rx_byte == snv_pkg::OP_MEM_WRITE)) begin
      clr_pend_reg <= 1'b1;
    end
  end

  // Write latch: volatile, set only by its own command
  always_ff @(posedge clk) begin
    if (rst) begin
      write_latch_flag_reg <= snv_pkg::LATCH_RST;
    end else if (set_evt) begin
      write_latch_flag_reg <= 1'b1;
    end else if (cs_rise && clr_pend_reg) begin
      write_latch_flag_reg <= 1'b0;
    end
  end

  // Guard bits and pin enable; restored from outside storage
  always_ff @(posedge clk) begin
    if (rst) begin
      block_guard_bit_low_reg  <= snv_pkg::GUARD_RST[0];
      block_guard_bit_high_reg <= snv_pkg::GUARD_RST[1];
      guard_pin_enable_reg     <= snv_pkg::PIN_EN_RST;
    end else if (nv_restore_valid) begin
      block_guard_bit_low_reg  <= nv_restore_guard[0];
      block_guard_bit_high_reg <= nv_restore_guard[1];
      guard_pin_enable_reg     <= nv_restore_pin_en;
    end else if (srw_take && srw_ok) begin
      // Latch bit in the data byte has no effect
      block_guard_bit_low_reg  <= rx_byte[snv_pkg::POS_GUARD_LOW];
      block_guard_bit_high_reg <= rx_byte[snv_pkg::POS_GUARD_HI];
      guard_pin_enable_reg     <= rx_byte[snv_pkg::POS_PIN_EN];
    end
  end

  // Status output register mirrors status for the storage side
  always_ff @(posedge clk) begin
    if (rst) begin
      status_protect_reg <= snv_pkg::STAT_FIXED;
    end else begin
      status_protect_reg <= status_now;
    end
  end

  // Status byte shifter, reloaded every eight bits
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_shift_reg <= 8'h00;
      tx_cnt_reg   <= 3'h0;
      so           <= 1'b0;
    end else if (byte_done && (state_reg == snv_pkg::ST_OPCODE)) begin
      tx_shift_reg <= status_now;
      tx_cnt_reg   <= 3'h0;
    end else if (sck_fall && (state_reg == snv_pkg::ST_SREAD)) begin
      so         <= tx_shift_reg[7];
      tx_cnt_reg <= tx_cnt_reg + 3'h1;
      if (tx_cnt_reg == snv_pkg::LAST_BIT) begin
        tx_shift_reg <= status_now;
      end else begin
        tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
      end
    end
  end

  // Output enable only while shifting the status byte
  always_ff @(posedge clk) begin
    if (rst || !cs_low || (state_reg != snv_pkg::ST_SREAD)) begin
      so_oe <= 1'b0;
    end else if (sck_fall) begin
      so_oe <= 1'b1;
    end
  end

  // Decoded command strobe for logic outside this block
  always_ff @(posedge clk) begin
    if (rst) begin
      cmd_strobe <= 1'b0;
      cmd_kind   <= snv_pkg::CMD_NONE;
    end else begin
      cmd_strobe <= 1'b0;
      if (byte_done && (state_reg == snv_pkg::ST_OPCODE)) begin
        cmd_strobe <= 1'b1;
        case (rx_byte)
          snv_pkg::OP_MEM_READ:  cmd_kind <= snv_pkg::CMD_READ;
          snv_pkg::OP_FAST_READ: cmd_kind <= snv_pkg::CMD_FAST_READ;
          snv_pkg::OP_SLEEP:     cmd_kind <= snv_pkg::CMD_SLEEP;
          snv_pkg::OP_ID_READ:   cmd_kind <= snv_pkg::CMD_ID_READ;
          default: begin
            cmd_strobe <= 1'b0;
            cmd_kind   <= snv_pkg::CMD_NONE;
          end
        endcase
      end
    end
  end

  // Mode captured from clock level at select
  always_ff @(posedge clk) begin
    if (rst) begin
      spi_mode3 <= 1'b0;
    end else if (cs_fall) begin
      spi_mode3 <= pin_sync_reg[1];
    end
  end

  // Two-entry write buffer; the serial side cannot stall, so a
  // full buffer drops the byte and raises a sticky overrun
  always_comb begin
    buf_in_ready = !slot1_valid_reg;
    buf_pop      = mem_wr_valid && mem_wr_ready;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mem_wr_valid    <= 1'b0;
      slot1_valid_reg <= 1'b0;
      mem_wr_word     <= '0;
      slot1_reg       <= '0;
    end else if (buf_pop) begin
      if (slot1_valid_reg) begin
        mem_wr_word     <= slot1_reg;
        slot1_valid_reg <= wr_take;
        slot1_reg       <= buf_in_word;
      end else begin
        mem_wr_valid <= wr_take;
        mem_wr_word  <= buf_in_word;
      end
    end else if (wr_take && buf_in_ready) begin
      // Byte leaves at its eighth bit, no page gathering
      if (!mem_wr_valid) begin
        mem_wr_valid <= 1'b1;
        mem_wr_word  <= buf_in_word;
      end else begin
        slot1_valid_reg <= 1'b1;
        slot1_reg       <= buf_in_word;
      end
    end
  end

  // Sticky overrun, cleared by reset only
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_overrun <= 1'b0;
    end else if (wr_take && !buf_in_ready && !buf_pop) begin
      wr_overrun <= 1'b1;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_opcode_byte;
    byte_done && (state_reg == snv_pkg::ST_OPCODE);
  endsequence
  sequence s_latch_up;
    !write_latch_flag_reg ##1 write_latch_flag_reg;
  endsequence

  a_latch_set_cause: assert property (
    s_latch_up |-> $past(set_evt))
    else $error("latch rose without set command");
  a_latch_clear_end: assert property (
    write_latch_flag_reg && cs_rise && clr_pend_reg |=> !write_latch_flag_reg)
    else $error("latch not cleared at deselect");
  a_status_fixed: assert property (
    ##1 (status_protect_reg[6:4] == 3'h4) && !status_protect_reg[0])
    else $error("fixed status bits wrong");
  a_deselect_quiet: assert property (
    !cs_low |=> !so_oe && (state_reg == snv_pkg::ST_IDLE))
    else $error("output driven while deselected");
  a_bad_op_quiet: assert property (
    s_opcode_byte ##1 (state_reg == snv_pkg::ST_IGNORE) |-> !so_oe)
    else $error("output driven after invalid opcode");
  a_write_commit: assert property (
    wr_take && buf_in_ready |=> mem_wr_valid)
    else $error("accepted byte not offered to array");
  a_refused_hold: assert property (
    byte_done && (state_reg == snv_pkg::ST_WDATA) && !wr_take
    |=> $stable(addr_reg))
    else $error("address moved on a refused byte");
  a_srw_refused: assert property (
    srw_take && !srw_ok && !nv_restore_valid |=> $stable(status_now[7:2]))
    else $error("refused status write changed bits");
  a_addr_step: assert property (
    wr_take |=> addr_reg == $past(addr_reg) + 18'h00001)
    else $error("burst address not incremented");
  a_opcode_first: assert property (
    cs_fall |=> (state_reg == snv_pkg::ST_OPCODE) && (bit_cnt_reg == 3'h0))
    else $error("select did not open opcode");
  a_mode_pick: assert property (
    cs_fall |=> spi_mode3 == $past(pin_sync_reg[1]))
    else $error("mode not taken from clock level");

endmodule

/* verif/snv_spi_master.sv */
`timescale 1ns/1ps
// Serial bus master model: owns select, clock and data-in pins
module snv_spi_master (
  // Bench clock paces every pin change
  clk,
  // Serial pins
  cs_n,
  sck,
  si,
  so
);
  input  wire logic clk;
  output logic      cs_n;
  output logic      sck;
  output logic      si;
  input  wire logic so;

  logic             mode3_reg;  // Idle clock level of this frame

  // Idle bus at time zero
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    mode3_reg = 1'b0;
  end

  // Half link period, 40 ns, changes at falling bench edges
  task automatic half();
    repeat (4) @(negedge clk);
  endtask

  // Clock parks at its mode level before select falls
  task automatic start(input logic m3);
    mode3_reg = m3;
    sck = m3;
    half();
    cs_n = 1'b0;
    half();
  endtask

  // One byte out MSB first, input sampled just before each rise
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sck = 1'b0;
      si = tx[i];
      half();
      rx[i] = so;
      sck = 1'b1;
      half();
    end
  endtask

  // Clock back to idle; released data line is inverted, not held
  task automatic stop();
    sck = mode3_reg;
    half();
    cs_n = 1'b1;
    si = ~si;
    half();
    half();
  endtask
endmodule

/* verif/tb_top.sv */
`timescale 1ns/1ps
// Self-checking bench for the serial command port
module tb_top;
  logic                  clk, rst, cs_n, sck, si, so, so_oe, so_pin;
  logic                  guard_pin_n, ready, hold, quiet, m3;
  logic                  nv_v, nv_pen, mode3, ovr, strobe, wvalid;
  logic [1:0]            nv_g;
  logic [7:0]            stat, rx;
  logic [7:0]            ops [4];   // Decoded-only opcodes
  snv_pkg::snv_cmd_t     kinds [4]; // Their expected kinds
  snv_pkg::snv_wr_word_t word;
  snv_pkg::snv_cmd_t     kind;
  snv_pkg::snv_wr_word_t wq[$];     // Notes of expected array words
  snv_pkg::snv_cmd_t     cq[$];     // Notes of expected commands
  int                    num_errors, num_checks, idle;

  assign so_pin = so_oe ? so : 1'bz;  // Undriven output floats

  snv_cmd_port snv_cmd_port_i (.clk(clk), .rst(rst), .cs_n(cs_n),
    .sck(sck), .si(si), .guard_pin_n(guard_pin_n), .so(so),
    .so_oe(so_oe), .nv_restore_valid(nv_v), .nv_restore_guard(nv_g),
    .nv_restore_pin_en(nv_pen), .status_protect_reg(stat),
    .mem_wr_word(word), .mem_wr_valid(wvalid), .mem_wr_ready(ready),
    .wr_overrun(ovr), .cmd_strobe(strobe), .cmd_kind(kind),
    .spi_mode3(mode3));
  snv_spi_master snv_spi_master_i (.clk(clk), .cs_n(cs_n), .sck(sck),
    .si(si), .so(so_pin));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Compare, count, report
  task automatic chk(input string what, input logic [25:0] exp, got);
    num_checks++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      num_errors++;
    end
  endtask

  // Verdict and end of run
  task automatic stop_test();
    $display("Checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // One select period: opcode, then n payload bytes from the top
  task automatic cmd(input logic [7:0] op, input logic [47:0] pay,
                     input int n);
    snv_spi_master_i.start(m3);
    snv_spi_master_i.xfer(op, rx);
    for (int i = 0; i < n; i++) begin
      snv_spi_master_i.xfer(pay[47-8*i -: 8], rx);
    end
    snv_spi_master_i.stop();
  endtask

  // Status read checked on the wire and at the port
  task automatic rd_stat(input logic [7:0] exp);
    cmd(snv_pkg::OP_STAT_READ, 48'h0, 1);
    chk("status byte", exp, rx);
    chk("status port", exp, stat);
    chk("mode", m3, mode3);
  endtask

  // Latch set in its own select period, as the master must
  task automatic arm();
    cmd(snv_pkg::OP_SET_LATCH, 48'h0, 0);
  endtask

  task automatic wr_stat(input logic [7:0] d);
    cmd(snv_pkg::OP_STAT_WRITE, {d, 40'h0}, 1);
  endtask

  task automatic ew(input logic [17:0] a, input logic [7:0] d);
    wq.push_back({a, d});
  endtask

  // Random stalls on the array side; hold forces a full stall.
  // Seeded here, since each process draws from its own generator
  initial begin
    ready = 1'b0;
    void'($urandom(91432));
    forever begin
      @(negedge clk);
      ready <= !hold && ($urandom % 4 != 0);
    end
  end

  // Watchers: take the oldest note whenever a result appears
  always @(posedge clk) begin
    if (rst === 1'b0 && wvalid === 1'b1 && ready === 1'b1) begin
      chk("array word", wq.size() ? wq.pop_front() : 26'hx, word);
    end
    if (rst === 1'b0 && strobe === 1'b1) begin
      chk("command", cq.size() ? cq.pop_front() : 3'hx, kind);
    end
    idle <= cs_n ? idle + 1 : 0;
    if ((idle > 6 || quiet) && so_oe !== 1'b0) begin
      chk("output enable", 1'b0, so_oe);
    end
  end

  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    num_errors++;
    stop_test();
  end

  // Main sequence
  initial begin
    rst = 1'b1;
    guard_pin_n = 1'b1;
    hold = 1'b0;
    quiet = 1'b0;
    nv_v = 1'b0;
    nv_g = 2'h0;
    nv_pen = 1'b0;
    m3 = 1'b0;
    num_errors = 0;
    num_checks = 0;
    idle = 0;
    ops = '{snv_pkg::OP_MEM_READ, snv_pkg::OP_FAST_READ,
            snv_pkg::OP_SLEEP, snv_pkg::OP_ID_READ};
    kinds = '{snv_pkg::CMD_READ, snv_pkg::CMD_FAST_READ,
              snv_pkg::CMD_SLEEP, snv_pkg::CMD_ID_READ};
    repeat (10) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    rd_stat(8'h40);
    nv_g = 2'h1;
    nv_pen = 1'b1;
    nv_v = 1'b1;
    @(negedge clk);
    nv_v = 1'b0;
    rd_stat(8'hc4);
    wr_stat(8'h00);
    rd_stat(8'hc4);
    m3 = 1'b1;
    arm();
    rd_stat(8'hc6);
    guard_pin_n = 1'b0;
    wr_stat(8'h00);
    rd_stat(8'hc4);
    guard_pin_n = 1'b1;
    arm();
    wr_stat(8'h02);
    rd_stat(8'h40);
    arm();
    cmd(snv_pkg::OP_CLR_LATCH, 48'h0, 0);
    rd_stat(8'h40);
    cmd(snv_pkg::OP_MEM_WRITE, 48'h0, 4);
    // Wrap at the top; pin enabled and low must not matter
    m3 = 1'b0;
    arm();
    wr_stat(8'h80);
    guard_pin_n = 1'b0;
    arm();
    ew(18'h3ffff, 8'ha5);
    ew(18'h00000, 8'h5a);
    ew(18'h00001, 8'h3c);
    cmd(snv_pkg::OP_MEM_WRITE, 48'hffffff_a55a3c, 6);
    rd_stat(8'hc0);
    guard_pin_n = 1'b1;
    // Every guard code against a burst crossing 30000h
    for (int g = 0; g < 4; g++) begin
      arm();
      wr_stat({4'h0, 2'(g), 2'h0});
      arm();
      if (g < 2) ew(18'h2ffff, 8'(g));
      if (g == 0) ew(18'h30000, 8'h77);
      cmd(snv_pkg::OP_MEM_WRITE, {24'h02ffff, 8'(g), 16'h7766}, 5);
    end
    arm();
    wr_stat(8'h00);
    for (int k = 0; k < 4; k++) begin
      cq.push_back(kinds[k]);
      cmd(ops[k], 48'h0, 2);
    end
    // Bad opcode: the following set-latch byte must be ignored
    quiet = 1'b1;
    cmd(8'h55, {snv_pkg::OP_SET_LATCH, 40'h0}, 2);
    quiet = 1'b0;
    rd_stat(8'h40);
    // Array stalled: two words kept, third lost and flagged
    hold = 1'b1;
    arm();
    ew(18'h00010, 8'h11);
    ew(18'h00011, 8'h22);
    cmd(snv_pkg::OP_MEM_WRITE, 48'h000010_112233, 6);
    chk("overrun", 1'b1, ovr);
    hold = 1'b0;
    for (int i = 0; i < 200 && wq.size() != 0; i++) @(negedge clk);
    chk("notes left", 26'h0, 26'(wq.size() + cq.size()));
    stop_test();
  end
endmodule
